// *** src/pipc_cfg.svh ***
/*
 * Offsets, field positions, reset values and fixed maps of the peripheral
 * interrupt priority controller. Assumes a 12-bit byte address seen by the
 * register slave and a 55-position source vector.
 */
`ifndef PIPC_CFG_SVH
`define PIPC_CFG_SVH

`define PIPC_NUM_SRC        55
`define PIPC_PRIO_W         3
`define PIPC_ID_W           6
`define PIPC_ADDR_W         12
`define PIPC_LOW_W          32
`define PIPC_HIGH_W         23

`define PIPC_OFS_SET_LOW    12'h100
`define PIPC_OFS_SET_HIGH   12'h104
`define PIPC_OFS_CLR_LOW    12'h180
`define PIPC_OFS_CLR_HIGH   12'h184
`define PIPC_OFS_PRIO_BASE  12'h400
`define PIPC_PRIO_WORDS     14
`define PIPC_OFS_IRQ_STATUS 12'h500
`define PIPC_OFS_IRQ_MASK   12'h504
`define PIPC_OFS_POWER_MODE 12'h508
`define PIPC_OFS_REQ_VIEW   12'h50C

`define PIPC_PRIO_RESET     3'h0
`define PIPC_RANK_LEVEL0    4'h4

`define PIPC_IMPL_MASK      55'h7F_F0FF_FFFF_A7FF
`define PIPC_DEEP_MASK      55'h00_0000_0000_07FF
`define PIPC_POS_DMA_ERR    25
`define PIPC_POS_DMA_DONE0  26
`define PIPC_DMA_CHANNELS   14

`define PIPC_EV_W           2
`define PIPC_EV_WAKE        0
`define PIPC_EV_REQ         1

`define PIPC_RESP_OKAY      2'h0
`define PIPC_RESP_SLVERR    2'h2

`endif

// *** src/pipc_pkg.sv ***
/*
 * Types shared by the interrupt priority controller.
 * Assumes nothing of its surroundings.
 */
package pipc_pkg;

   typedef enum logic [1:0] {
      PIPC_MODE_ACTIVE = 2'b00,
      PIPC_MODE_LIGHT  = 2'b01,
      PIPC_MODE_DEEP_A = 2'b10,
      PIPC_MODE_DEEP_B = 2'b11
   } pipc_mode_type;

endpackage

// *** src/pipc_prio_pick.sv ***
/*
 * Combinational picker: most urgent requesting position, lowest index on a tie.
 * Assumes priorities packed W bits per position, position 0 in the low bits.
 */
`timescale 1ns/1ns
module pipc_prio_pick
#(
   parameter int N   = 55,
   parameter int W   = 3,
   parameter int IDW = 6
)
(
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic [N-1:0]   req,
   input  wire logic [N*W-1:0] prio,
   output logic                found,
   output logic [IDW-1:0]      id,
   output logic [W-1:0]        best_prio
);

   logic better_seen;

   always_comb
   begin
      found     = 1'b0;
      id        = '0;
      best_prio = '0;
      // strict compare keeps the earlier (lower) position on equal levels
      for (int i = 0; i < N; i++)
      begin
         if (req[i] && (!found || (prio[i*W +: W] < best_prio)))
         begin
            found     = 1'b1;
            id        = IDW'(i);
            best_prio = prio[i*W +: W];
         end
      end
   end

   // checking helper: any request that should have beaten the winner
   always_comb
   begin
      better_seen = 1'b0;
      for (int i = 0; i < N; i++)
      begin
         if (found && req[i] && (prio[i*W +: W] < best_prio))
            better_seen = 1'b1;
         if (found && req[i] && (IDW'(i) < id) && (prio[i*W +: W] == best_prio))
            better_seen = 1'b1;
      end
   end

   AST_PICK_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
      found |-> (!better_seen && req[id])) // [R05]
      else $error("picker chose a position that is not the most urgent");

endmodule // pipc_prio_pick

// *** src/pipc_axil_slave.sv ***
/*
 * AXI4-Lite slave front end: one write and one read in flight, write address
 * and data taken in either order. Assumes the owner decodes addresses and
 * returns read data and both ok flags combinationally.
 */
`timescale 1ns/1ns
`include "pipc_cfg.svh"
module pipc_axil_slave
#(
   parameter int AW = 12
)
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   output logic               wr_fire,
   output logic [AW-1:0]      wr_addr,
   output logic [31:0]        wr_data,
   output logic [3:0]         wr_strb,
   input  wire logic          wr_ok,
   output logic [AW-1:0]      rd_addr,
   input  wire logic [31:0]   rd_data,
   input  wire logic          rd_ok
);

   logic aw_full_q;
   logic aw_full_d;
   logic w_full_q;
   logic w_full_d;
   logic bvalid_d;
   logic rvalid_d;
   wire  aw_hs = awvalid & awready;
   wire  w_hs  = wvalid & wready;
   wire  ar_hs = arvalid & arready;

   assign wr_fire   = aw_full_q & w_full_q;
   assign rd_addr   = araddr;
   assign aw_full_d = (aw_full_q | aw_hs) & ~wr_fire;
   assign w_full_d  = (w_full_q | w_hs) & ~wr_fire;
   assign bvalid_d  = wr_fire | (bvalid & ~bready);
   assign rvalid_d  = ar_hs | (rvalid & ~rready);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `PIPC_RESP_OKAY;
         wr_addr   <= '0;
         wr_data   <= 32'h0;
         wr_strb   <= 4'h0;
      end
      else
      begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         // readies stay low while a response waits, so one write at a time
         awready   <= ~aw_full_d & ~bvalid_d;
         wready    <= ~w_full_d & ~bvalid_d;
         bvalid    <= bvalid_d;
         if (wr_fire)
            bresp <= wr_ok ? `PIPC_RESP_OKAY : `PIPC_RESP_SLVERR;
         if (aw_hs)
            wr_addr <= awaddr;
         if (w_hs)
         begin
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `PIPC_RESP_OKAY;
      end
      else
      begin
         arready <= ~rvalid_d;
         rvalid  <= rvalid_d;
         if (ar_hs)
         begin
            rdata <= rd_ok ? rd_data : 32'h0;
            rresp <= rd_ok ? `PIPC_RESP_OKAY : `PIPC_RESP_SLVERR;
         end
      end
   end

endmodule // pipc_axil_slave

// *** src/pipc_top.sv ***
/*
 * Peripheral interrupt priority controller: enable set/clear, 3-bit priority
 * per position, most urgent request to the core, and low power wake control.
 * Assumes all sources are levels synchronous to clk and the core reports
 * whether a handler runs and at which level.
 */
// Our own choices: the AXI4-Lite register port and the register addresses.
// Operation
// [R01] positions 20-54 wake light sleep only
// [R02] three-bit priority, lower value more urgent
// [R03] all priority fields reset to zero
// [R04] level zero ranks fourth overall
// [R05] equal level: lower position wins
// [R06] low set word bit n enables n
// [R07] low clear word bit n disables n
// [R08] positions 32-54 sit in high words
// [R09] DMA error 25, channel done 26-39
// [R10] only positions 0-10 wake deep modes
// [R11] deep mode wake returns to active
// [R12] in handler only more urgent wakes
// [R13] enable reads show state, reserved zero
`timescale 1ns/1ns
`include "pipc_cfg.svh"
module pipc_top
   import pipc_pkg::*;
#(
   parameter int N   = `PIPC_NUM_SRC,
   parameter int W   = `PIPC_PRIO_W,
   parameter int IDW = `PIPC_ID_W,
   parameter int AW  = `PIPC_ADDR_W
)
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [AW-1:0]                 s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [AW-1:0]                 s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [N-1:0]                  periph_irq,
   input  wire logic                          dma_error,
   input  wire logic [`PIPC_DMA_CHANNELS-1:0] dma_done,
   input  wire logic                          handler_active,
   input  wire logic [W-1:0]                  active_prio,
   output logic                               exc_req_q,
   output logic [IDW-1:0]                     exc_id_q,
   output logic [W-1:0]                       exc_prio_q,
   output logic [3:0]                         exc_rank_q,
   output logic [1:0]                         power_mode_q,
   output logic                               wake_q,
   output logic                               irq_q
);

   logic [AW-1:0]          wr_addr;
   logic [AW-1:0]          rd_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   logic                   wr_fire;
   logic [N-1:0]           enable_q;
   logic [N-1:0]           enable_d;
   logic [N*W-1:0]         prio_q;
   logic [N*W-1:0]         prio_d;
   logic [`PIPC_EV_W-1:0]  status_q;
   logic [`PIPC_EV_W-1:0]  status_d;
   logic [`PIPC_EV_W-1:0]  mask_q;
   logic [`PIPC_EV_W-1:0]  mask_d;
   pipc_mode_type          mode_q;
   pipc_mode_type          mode_d;
   logic [N-1:0]           wake_mask;
   logic                   req_found;
   logic [IDW-1:0]         req_id;
   logic [W-1:0]           req_prio;
   logic                   cand_found;
   logic [W-1:0]           cand_prio;
   logic [31:0]            prio_rd_word;
   logic [31:0]            rd_data;

   ////////////////////////////////////////////////////////////////////////////
   // source vector: DMA lines take their fixed positions
   wire [N-1:0] dma_pos  = N'({dma_done, dma_error}) << `PIPC_POS_DMA_ERR; // [R09]
   wire [N-1:0] dma_keep = N'({(`PIPC_DMA_CHANNELS + 1){1'b1}}) << `PIPC_POS_DMA_ERR;
   wire [N-1:0] impl     = N'(`PIPC_IMPL_MASK);
   wire [N-1:0] src_vec  = ((periph_irq & ~dma_keep) | dma_pos) & impl;
   wire [N-1:0] live     = src_vec & enable_q;

   ////////////////////////////////////////////////////////////////////////////
   // write decode
   wire [31:0]   wmask    = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire [31:0]   wbits    = wr_data & wmask;
   wire          hit_setl = wr_fire & (wr_addr == `PIPC_OFS_SET_LOW);
   wire          hit_seth = wr_fire & (wr_addr == `PIPC_OFS_SET_HIGH);
   wire          hit_clrl = wr_fire & (wr_addr == `PIPC_OFS_CLR_LOW);
   wire          hit_clrh = wr_fire & (wr_addr == `PIPC_OFS_CLR_HIGH);
   wire          hit_stat = wr_fire & (wr_addr == `PIPC_OFS_IRQ_STATUS);
   wire          hit_mask = wr_fire & (wr_addr == `PIPC_OFS_IRQ_MASK);
   wire          hit_mode = wr_fire & (wr_addr == `PIPC_OFS_POWER_MODE) & wr_strb[0];
   wire [AW-1:0] wp_off   = wr_addr - `PIPC_OFS_PRIO_BASE;
   wire [AW-3:0] wp_idx   = wp_off[AW-1:2];
   wire          wp_in    = (wr_addr >= `PIPC_OFS_PRIO_BASE) & (wp_off[1:0] == 2'h0)
                            & (wp_idx < (AW-2)'(`PIPC_PRIO_WORDS));
   wire          hit_prio = wr_fire & wp_in;
   wire          wr_ok    = hit_setl | hit_seth | hit_clrl | hit_clrh | hit_stat
                            | hit_mask | (wr_addr == `PIPC_OFS_POWER_MODE) | wp_in
                            | (wr_addr == `PIPC_OFS_REQ_VIEW);

   wire [N-1:0] set_bits = (hit_setl ? N'(wbits) : '0)                          // [R06]
                           | (hit_seth ? N'(wbits[`PIPC_HIGH_W-1:0]) << `PIPC_LOW_W : '0); // [R08]
   wire [N-1:0] clr_bits = (hit_clrl ? N'(wbits) : '0)                          // [R07]
                           | (hit_clrh ? N'(wbits[`PIPC_HIGH_W-1:0]) << `PIPC_LOW_W : '0); // [R08]

   // set wins if the same position is set and cleared together
   assign enable_d = ((enable_q & ~clr_bits) | set_bits) & impl; // [R13]

   always_comb
   begin
      prio_d = prio_q;
      for (int i = 0; i < N; i++)
      begin
         if (hit_prio && (wp_idx == (AW-2)'(i / 4)) && wr_strb[i % 4])
            prio_d[i*W +: W] = wr_data[(i % 4)*8 +: W]; // [R02]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pickers: one for the core request, one for wake candidates
   pipc_prio_pick #(.N(N), .W(W), .IDW(IDW)) u_req_pick
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .req       (live),
      .prio      (prio_q),
      .found     (req_found),
      .id        (req_id),
      .best_prio (req_prio)
   );

   pipc_prio_pick #(.N(N), .W(W), .IDW(IDW)) u_wake_pick
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .req       (live & wake_mask),
      .prio      (prio_q),
      .found     (cand_found),
      .id        (),
      .best_prio (cand_prio)
   );

   always_comb
   begin
      case (mode_q)
         PIPC_MODE_LIGHT:  wake_mask = impl;                    // [R01]
         PIPC_MODE_DEEP_A: wake_mask = N'(`PIPC_DEEP_MASK);     // [R10]
         PIPC_MODE_DEEP_B: wake_mask = N'(`PIPC_DEEP_MASK);     // [R10]
         default:          wake_mask = '0;
      endcase
   end

   // lower value is more urgent, so a wake during a handler needs a strictly smaller level
   wire wake_now = cand_found & (~handler_active | (cand_prio < active_prio)); // [R12]

   assign mode_d = wake_now ? PIPC_MODE_ACTIVE                     // [R11]
                 : hit_mode ? pipc_mode_type'(wr_data[1:0]) : mode_q;

   ////////////////////////////////////////////////////////////////////////////
   // event status, write one to clear; a new event beats its own clear
   wire [`PIPC_EV_W-1:0] ev_now = {req_found & ~exc_req_q, wake_now};
   assign status_d = (status_q & ~(hit_stat ? wbits[`PIPC_EV_W-1:0] : '0)) | ev_now;
   assign mask_d   = hit_mask ? wbits[`PIPC_EV_W-1:0] : mask_q;

   ////////////////////////////////////////////////////////////////////////////
   // read decode
   wire [AW-1:0] rp_off = rd_addr - `PIPC_OFS_PRIO_BASE;
   wire [AW-3:0] rp_idx = rp_off[AW-1:2];
   wire          rp_in  = (rd_addr >= `PIPC_OFS_PRIO_BASE) & (rp_off[1:0] == 2'h0)
                          & (rp_idx < (AW-2)'(`PIPC_PRIO_WORDS));
   wire          rd_low = (rd_addr == `PIPC_OFS_SET_LOW) | (rd_addr == `PIPC_OFS_CLR_LOW);
   wire          rd_hi  = (rd_addr == `PIPC_OFS_SET_HIGH) | (rd_addr == `PIPC_OFS_CLR_HIGH);
   wire          rd_st  = rd_addr == `PIPC_OFS_IRQ_STATUS;
   wire          rd_mk  = rd_addr == `PIPC_OFS_IRQ_MASK;
   wire          rd_md  = rd_addr == `PIPC_OFS_POWER_MODE;
   wire          rd_rv  = rd_addr == `PIPC_OFS_REQ_VIEW;
   wire          rd_ok  = rd_low | rd_hi | rd_st | rd_mk | rd_md | rd_rv | rp_in;
   wire [31:0]   rd_view = {6'h0, power_mode_q, 7'h0, exc_req_q, 5'h0, exc_prio_q,
                            2'h0, exc_id_q};

   always_comb
   begin
      prio_rd_word = 32'h0;
      for (int b = 0; b < 4; b++)
      begin
         for (int i = 0; i < N; i++)
         begin
            if ((i % 4 == b) && (rp_idx == (AW-2)'(i / 4)))
               prio_rd_word[b*8 +: W] = prio_q[i*W +: W];
         end
      end
   end

   assign rd_data = rd_low ? enable_q[`PIPC_LOW_W-1:0]                          // [R13]
                  : rd_hi ? 32'(enable_q[N-1:`PIPC_LOW_W])                      // [R13]
                  : rd_st ? 32'(status_q)
                  : rd_mk ? 32'(mask_q)
                  : rd_md ? 32'(power_mode_q)
                  : rd_rv ? rd_view
                  : rp_in ? prio_rd_word : 32'h0;

   pipc_axil_slave #(.AW(AW)) u_bus
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_fire (wr_fire),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (wr_ok),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         enable_q <= '0;
         prio_q   <= {N{`PIPC_PRIO_RESET}}; // [R03]
         status_q <= '0;
         mask_q   <= '0;
         mode_q   <= PIPC_MODE_ACTIVE;
      end
      else
      begin
         enable_q <= enable_d;
         prio_q   <= prio_d;
         status_q <= status_d;
         mask_q   <= mask_d;
         mode_q   <= mode_d;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         exc_req_q    <= 1'b0;
         exc_id_q     <= '0;
         exc_prio_q   <= '0;
         exc_rank_q   <= `PIPC_RANK_LEVEL0;
         power_mode_q <= PIPC_MODE_ACTIVE;
         wake_q       <= 1'b0;
         irq_q        <= 1'b0;
      end
      else
      begin
         exc_req_q    <= req_found;
         exc_id_q     <= req_id;
         exc_prio_q   <= req_prio;
         exc_rank_q   <= {1'b0, req_prio} + `PIPC_RANK_LEVEL0; // [R04]
         power_mode_q <= mode_d;
         wake_q       <= wake_now;
         irq_q        <= |(status_d & mask_d);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_DEEP_ONLY_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      ((mode_q == PIPC_MODE_DEEP_A || mode_q == PIPC_MODE_DEEP_B)
       && ((live & N'(`PIPC_DEEP_MASK)) == '0)) |-> !wake_now) // [R10]
      else $error("deep mode woken by a position above 10");

   AST_LIGHT_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_q == PIPC_MODE_LIGHT && (|live) && !handler_active)
      |=> (power_mode_q == PIPC_MODE_ACTIVE && wake_q)) // [R01]
      else $error("enabled source failed to wake light sleep");

   AST_PRIO_RESET: assert property (@(posedge clk)
      !rst_n |=> (prio_q == '0 && exc_prio_q == '0)) // [R03]
      else $error("priority fields not zero after reset");

   AST_RANK_FOURTH: assert property (@(posedge clk) disable iff (!rst_n)
      exc_req_q |-> (exc_rank_q == {1'b0, exc_prio_q} + `PIPC_RANK_LEVEL0)) // [R04]
      else $error("request rank not level plus four");

   AST_SET_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      hit_setl |=> ((enable_q & $past(set_bits & impl)) == $past(set_bits & impl))) // [R06]
      else $error("low set word failed to enable");

   AST_CLR_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      (hit_clrl && !hit_setl) |=> ((enable_q & $past(clr_bits)) == '0)) // [R07]
      else $error("low clear word failed to disable");

   AST_HIGH_MAP: assert property (@(posedge clk) disable iff (!rst_n)
      (hit_seth && wbits[0]) |=> enable_q[`PIPC_LOW_W]) // [R08]
      else $error("high set bit 0 did not enable position 32");

   AST_DMA_MAP: assert property (@(posedge clk) disable iff (!rst_n)
      (src_vec[`PIPC_POS_DMA_ERR] == dma_error)
      && (src_vec[`PIPC_POS_DMA_DONE0 +: `PIPC_DMA_CHANNELS] == dma_done)) // [R09]
      else $error("DMA lines not at their fixed positions");

   AST_DEEP_RETURN: assert property (@(posedge clk) disable iff (!rst_n)
      wake_now |=> (power_mode_q == PIPC_MODE_ACTIVE && wake_q)) // [R11]
      else $error("wake did not return to active mode");

   AST_HANDLER_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
      (handler_active && cand_prio >= active_prio) |-> !wake_now) // [R12]
      else $error("wake by a source not more urgent than the handler");

   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (enable_q & ~impl) == '0) // [R13]
      else $error("reserved position shows as enabled");

   AST_TIE_LOW_POS: assert property (@(posedge clk) disable iff (!rst_n)
      (live[0] && live[1] && prio_q[W-1:0] == '0 && prio_q[2*W-1:W] == '0)
      |=> (exc_id_q == '0)) // [R05]
      else $error("tie not won by the lower position");

endmodule // pipc_top

// *** test/pipc_core_model.sv ***
/*
 * Core model: reports a running handler and its level.
 * Assumes the bench says when a handler starts and at which level.
 */
`timescale 1ns/1ns
module pipc_core_model
#(
   parameter int LAT = 1
)
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [2:0] lvl,
   output logic            handler_active,
   output logic [2:0]      active_prio
);
   logic [7:0] busy_q;
   // entry shows LAT edges late, like a core still stacking
   assign handler_active = busy_q[LAT-1];
   always_ff @(posedge clk)
   begin
      busy_q      <= rst_n ? {busy_q[6:0], go} : 8'h00;
      active_prio <= lvl;
   end
endmodule // pipc_core_model

// *** test/tb_top.sv ***
/*
 * Bench for the interrupt priority controller: AXI4-Lite reads are
 * checked against a queue of expected words. Assumes a 20 MHz clock.
 */
`timescale 1ns/1ns
module tb_top;
   logic        clk = 0, rst_n = 0, go = 0, dma_error = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, exc_req_q, wake_q, irq_q, handler_active;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF, exc_rank_q;
   logic [1:0]  s_axi_bresp, s_axi_rresp, power_mode_q;
   logic [54:0] periph_irq = 0;
   logic [13:0] dma_done = 0;
   logic [2:0]  lvl = 0, active_prio, exc_prio_q;
   logic [5:0]  exc_id_q;
   logic [33:0] expq[$];
   logic [1:0]  expb[$];
   int          fail_count = 0, n_tests = 0;
   int          n_wake = 0;
   pipc_top pipc_top_inst (.*);
   pipc_core_model #(.LAT(3)) pipc_core_model_inst (.*);
   initial forever #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      n_tests++;
      if (s !== e)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [33:0] vw(logic r, int l, int id, logic [1:0] m);
      return {8'h0, m, 7'h0, r, 5'h0, 3'(l), 2'h0, 6'(id)};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] eb = 2'h0);
      logic ta = 0, tw = 0, tb = 0;
      expb.push_back(eb);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!tb)
      begin
         @(negedge clk);
         ta |= s_axi_awready & s_axi_awvalid;
         tw |= s_axi_wready & s_axi_wvalid;
         tb = s_axi_bvalid;
         @(posedge clk);
         if (ta) s_axi_awvalid <= '0;
         if (tw) s_axi_wvalid <= '0;
      end
      s_axi_bready <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      logic ta = 0, tr = 0;
      expq.push_back(e);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (!tr)
      begin
         @(negedge clk);
         ta |= s_axi_arready & s_axi_arvalid;
         tr = s_axi_rvalid;
         @(posedge clk);
         if (ta) s_axi_arvalid <= '0;
      end
      s_axi_rready <= '0;
   endtask
   // read checker: oldest note against each accepted read beat
   always @(negedge clk)
   begin
      if (s_axi_rvalid && s_axi_rready)
      begin
         if (expq.size() == 0) chk('1, '0);
         else chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready && expb.size() > 0)
         chk(34'(s_axi_bresp), 34'(expb.pop_front()));
   end
   // each wake is a one-cycle pulse, counted here
   always @(negedge clk)
      if (wake_q) n_wake++;
   task automatic irqchk(input logic [11:0] a, input logic [31:0] d, input logic e);
      wr(a, d);
      @(negedge clk);
      chk(34'(irq_q), 34'(e));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] d;
      logic [3:0]  s;
      int          bl, bi;
      void'($urandom(94));
      repeat (10) @(posedge clk);
      rst_n <= '1;
      rd(12'h400, 34'h0);
      rd(12'h434, 34'h0);
      rd(12'h010, 34'h2_0000_0000);
      wr(12'h010, '1, 2'h2);
      wr(12'h100, 32'h10);
      rd(12'h180, 34'h10);
      wr(12'h180, 32'h0);
      rd(12'h100, 34'h10);
      wr(12'h180, 32'h10);
      rd(12'h100, 34'h0);
      wr(12'h100, '1);
      wr(12'h104, '1);
      rd(12'h180, 34'hFFFFA7FF);
      rd(12'h104, 34'h7FF0FF);
      $display("test enables done");
      for (int k = 0; k < 15; k++)
      begin
         {dma_error, dma_done} <= (k == 14) ? 15'h4000 : 15'h1 << k;
         rd(12'h50C, vw(1, 0, (k == 14) ? 25 : 26 + k, 0));
      end
      {dma_error, dma_done} <= '0;
      for (int i = 0; i < 8; i++)
      begin
         d = $urandom;
         s = 4'($urandom_range(15, 1));
         {bl, bi} = {32'd8, 32'd0};
         for (int b = 3; b >= 0; b--)
            if (s[b] && d[8*b+:3] <= bl) {bl, bi} = {32'(d[8*b+:3]), 32'(b)};
         wr(12'h414, d);
         periph_irq[23:20] <= s;
         rd(12'h414, {2'h0, d & 32'h07070707});
         rd(12'h50C, vw(1, bl, 20 + bi, 0));
         chk(34'(exc_rank_q), 34'(bl + 4));
      end
      periph_irq <= 55'h3;
      rd(12'h50C, vw(1, 0, 0, 0));
      periph_irq <= '0;
      $display("test priority done");
      wr(12'h414, 32'h0);
      wr(12'h508, 32'h2);
      periph_irq[20] <= '1;
      rd(12'h50C, vw(1, 0, 20, 2));
      periph_irq[5] <= '1;
      rd(12'h50C, vw(1, 0, 5, 0));
      irqchk(12'h504, 32'h1, 1);
      irqchk(12'h504, 32'h0, 0);
      irqchk(12'h504, 32'h1, 1);
      irqchk(12'h500, 32'h3, 0);
      wr(12'h508, 32'h1);
      rd(12'h50C, vw(1, 0, 5, 0));
      wr(12'h508, 32'h3);
      rd(12'h50C, vw(1, 0, 5, 0));
      periph_irq <= '0;
      wr(12'h414, 32'h3);
      {go, lvl} <= 4'hA;
      wr(12'h508, 32'h1);
      periph_irq[20] <= '1;
      rd(12'h50C, vw(1, 3, 20, 1));
      wr(12'h414, 32'h1);
      rd(12'h50C, vw(1, 1, 20, 0));
      chk(34'(n_wake), 34'h4);
      $display("test wake done");
      print_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
endmodule // tb_top
